// [adcrs_core.sv]
/*
 Converter control block: AXI4-Lite register slave, conversion sequencer,
 result placement, sleep and reset handling, interrupt status and mask.
 Assumes a synchronous analog comparator path that delivers a 10-bit code
 on sample_i while the sequencer asks with sample_req_o, and a power-on
 reset input separate from the general device reset.
*/
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "adcrs_regs.svh"
module adcrs_core #(
   parameter int INSTR_CLKS = `ADCRS_INSTR_CLKS,
   parameter int RC_CLKS    = `ADCRS_RC_CLKS
) (
   input  wire logic        sys_clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        por_n_i,
   input  wire logic        sleep_i,
   input  wire logic [11:0] s_axi_awaddr_i,
   input  wire logic        s_axi_awvalid_i,
   output logic             s_axi_awready_o,
   input  wire logic [31:0] s_axi_wdata_i,
   input  wire logic [3:0]  s_axi_wstrb_i,
   input  wire logic        s_axi_wvalid_i,
   output logic             s_axi_wready_o,
   output logic [1:0]       s_axi_bresp_o,
   output logic             s_axi_bvalid_o,
   input  wire logic        s_axi_bready_i,
   input  wire logic [11:0] s_axi_araddr_i,
   input  wire logic        s_axi_arvalid_i,
   output logic             s_axi_arready_o,
   output logic [31:0]      s_axi_rdata_o,
   output logic [1:0]       s_axi_rresp_o,
   output logic             s_axi_rvalid_o,
   input  wire logic        s_axi_rready_i,
   input  wire logic [9:0]  sample_i,
   output logic             sample_req_o,
   output logic             analog_power_o,
   output logic             wake_o,
   output logic             irq_o
);
   // Counters are eight bits wide; refuse counts they cannot hold
   if (INSTR_CLKS < 1 || INSTR_CLKS > 255 || RC_CLKS < 2 || RC_CLKS > 255) begin
      $error("adcrs_core: timing parameter out of range");
   end

   adcrs_pkg::adcrs_state_t state_reg;
   logic [7:0]  flags_reg;
   logic [7:0]  enables_reg;
   logic [7:0]  control_reg;
   logic [7:0]  config_reg;
   logic [7:0]  res_low_reg;
   logic [7:0]  res_high_reg;
   logic [1:0]  irq_stat_reg;
   logic [1:0]  irq_mask_reg;
   logic [7:0]  div_reg;
   logic [7:0]  phase_reg;
   logic [3:0]  period_reg;
   logic        powered_reg;
   logic        sleep_d_reg;
   logic        aw_hold_reg;
   logic        w_hold_reg;
   logic [9:0]  aw_idx_reg;
   logic [31:0] w_data_reg;
   logic        w_lane_reg;

   adcrs_pkg::adcrs_sample_t done_s;
   adcrs_pkg::adcrs_clksel_t clk_sel;
   logic        tick;
   logic        wr_fire;
   logic        rd_fire;
   logic [9:0]  rd_idx;
   logic        conv_on;
   logic        start_bit;
   logic        sw_start_clr;
   logic        sleep_rise;
   logic        abort_sleep;
   logic        done_sleep_quiet;
   logic [15:0] placed;
   logic [7:0]  wbyte;

   function automatic logic [15:0] place_result(input logic fmt, input logic [9:0] c);
      place_result = fmt ? {6'h00, c} : {c, 6'h00};
   endfunction : place_result

   function automatic logic [7:0] div_of(input adcrs_pkg::adcrs_clksel_t s, input int rc);
      case (s)
         adcrs_pkg::ADCRS_CLK_DIV8:  div_of = 8'(`ADCRS_DIV_8);
         adcrs_pkg::ADCRS_CLK_DIV32: div_of = 8'(`ADCRS_DIV_32);
         adcrs_pkg::ADCRS_CLK_DIV64: div_of = 8'(`ADCRS_DIV_64);
         default:                    div_of = 8'(rc);
      endcase
   endfunction : div_of

   assign clk_sel    = adcrs_pkg::adcrs_clksel_t'(config_reg[7:6]);
   assign conv_on    = control_reg[`ADCRS_BIT_ON];
   assign start_bit  = control_reg[`ADCRS_BIT_START];
   assign sleep_rise = sleep_i && !sleep_d_reg;
   assign wr_fire    = aw_hold_reg && w_hold_reg && !s_axi_bvalid_o;
   assign rd_fire    = s_axi_arvalid_i && s_axi_arready_o;
   assign rd_idx     = s_axi_araddr_i[11:2];
   assign wbyte      = w_data_reg[7:0];
   // Only the low lane carries a register; a write without it changes nothing
   assign sw_start_clr = wr_fire && w_lane_reg && aw_idx_reg == 10'(`ADCRS_IDX_CONTROL)
                         && !wbyte[`ADCRS_BIT_START];
   // Oscillator-derived periods tick on phase 0 of the divider, which is where
   // the host phase clocks are quiet; RC periods have no such alignment
   assign tick = (div_reg == 8'h00);
   assign abort_sleep = sleep_rise && clk_sel != adcrs_pkg::ADCRS_CLK_RC
                        && state_reg != adcrs_pkg::ADCRS_IDLE;
   // A converter switched off in the last period must not load a result
   assign done_s.valid = state_reg == adcrs_pkg::ADCRS_CONV && tick && conv_on
                         && period_reg == 4'(`ADCRS_CONV_PERIODS - 1);
   assign done_s.code  = sample_i;   // Code steps of span/1024 come from the analog side
   assign done_sleep_quiet = done_s.valid && sleep_i && !enables_reg[`ADCRS_BIT_IRQ_FLAG];
   assign placed = place_result(config_reg[`ADCRS_BIT_FORMAT], done_s.code);

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sleep_d_reg <= 1'b0;
      end else begin
         sleep_d_reg <= sleep_i;
      end
   end

   // Conversion clock divider; reloads on every period
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         div_reg <= 8'h00;
      end else if (state_reg == adcrs_pkg::ADCRS_IDLE || tick) begin
         div_reg <= div_of(clk_sel, RC_CLKS) - 8'h01;
      end else begin
         div_reg <= div_reg - 8'h01;
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_reg  <= adcrs_pkg::ADCRS_IDLE;
         phase_reg  <= 8'h00;
         period_reg <= 4'h0;
      end else if (!conv_on || abort_sleep || done_sleep_quiet) begin
         state_reg  <= adcrs_pkg::ADCRS_IDLE;
         period_reg <= 4'h0;
      end else begin
         case (state_reg)
            adcrs_pkg::ADCRS_IDLE: begin
               if (start_bit && powered_reg) begin
                  phase_reg <= 8'(INSTR_CLKS - 1);
                  state_reg <= (clk_sel == adcrs_pkg::ADCRS_CLK_RC) ?
                               adcrs_pkg::ADCRS_DELAY : adcrs_pkg::ADCRS_CONV;
               end
            end
            adcrs_pkg::ADCRS_DELAY: begin
               if (phase_reg == 8'h00) begin
                  state_reg <= adcrs_pkg::ADCRS_CONV;
               end else begin
                  phase_reg <= phase_reg - 8'h01;
               end
            end
            adcrs_pkg::ADCRS_CONV: begin
               if (sw_start_clr || done_s.valid) begin
                  state_reg  <= adcrs_pkg::ADCRS_WAIT;
                  period_reg <= 4'h0;
               end else if (tick) begin
                  period_reg <= period_reg + 4'h1;
               end
            end
            adcrs_pkg::ADCRS_WAIT: begin
               if (tick) begin
                  if (period_reg == 4'(`ADCRS_ABORT_PERIODS - 1)) begin
                     state_reg <= adcrs_pkg::ADCRS_IDLE;   // acquisition restarts
                  end else begin
                     period_reg <= period_reg + 4'h1;
                  end
               end
            end
            default: state_reg <= adcrs_pkg::ADCRS_IDLE;
         endcase
      end
   end

   // Analog power: off at reset, off after a sleep abort or quiet completion,
   // back on when software writes the control register with the on bit set
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         powered_reg <= 1'b0;
      end else if (abort_sleep || done_sleep_quiet) begin
         powered_reg <= 1'b0;
      end else if (wr_fire && w_lane_reg && aw_idx_reg == 10'(`ADCRS_IDX_CONTROL)) begin
         powered_reg <= wbyte[`ADCRS_BIT_ON];
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         analog_power_o <= 1'b0;
         sample_req_o   <= 1'b0;
         wake_o         <= 1'b0;
      end else begin
         analog_power_o <= powered_reg && conv_on;
         sample_req_o   <= state_reg == adcrs_pkg::ADCRS_CONV;
         wake_o         <= done_s.valid && sleep_i
                           && enables_reg[`ADCRS_BIT_IRQ_FLAG];
      end
   end

   // Control, config, flag and enable registers; hardware set wins over write
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         flags_reg   <= `ADCRS_RST_FLAGS;
         enables_reg <= `ADCRS_RST_ENABLES;
         control_reg <= `ADCRS_RST_CONTROL;
         config_reg  <= `ADCRS_RST_CONFIG;
      end else begin
         if (wr_fire && w_lane_reg) begin
            if (aw_idx_reg == 10'(`ADCRS_IDX_FLAGS)) begin
               flags_reg <= wbyte & `ADCRS_MASK_FLAGS;
            end else if (aw_idx_reg == 10'(`ADCRS_IDX_ENABLES)) begin
               enables_reg <= wbyte & `ADCRS_MASK_FLAGS;
            end else if (aw_idx_reg == 10'(`ADCRS_IDX_CONTROL)) begin
               control_reg <= wbyte & `ADCRS_MASK_CONTROL;
            end else if (aw_idx_reg == 10'(`ADCRS_IDX_CONFIG)) begin
               config_reg <= wbyte & `ADCRS_MASK_CONFIG;
            end
         end
         if (done_s.valid) begin
            flags_reg[`ADCRS_BIT_IRQ_FLAG]     <= 1'b1;
            control_reg[`ADCRS_BIT_START]      <= 1'b0;
         end
         if (abort_sleep) begin
            control_reg[`ADCRS_BIT_START] <= 1'b0;
         end
      end
   end

   // Result pair: no reset term, so power-on leaves it unknown and other
   // resets keep it; por_n_i only tells the sequencer nothing here
   always_ff @(posedge sys_clk_i) begin
      if (done_s.valid) begin
         {res_high_reg, res_low_reg} <= placed;
      end else if (wr_fire && w_lane_reg && !conv_on) begin
         if (aw_idx_reg == 10'(`ADCRS_IDX_RES_LOW)) begin
            res_low_reg <= wbyte;
         end else if (aw_idx_reg == 10'(`ADCRS_IDX_RES_HIGH)) begin
            res_high_reg <= wbyte;
         end
      end
   end

   // Interrupt status: bit0 completion, bit1 sleep abort; read clears, set wins
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         irq_stat_reg <= 2'b00;
         irq_mask_reg <= 2'b00;
         irq_o        <= 1'b0;
      end else begin
         irq_stat_reg <= ((rd_fire && rd_idx == 10'(`ADCRS_IDX_IRQ_STAT)) ? 2'b00 : irq_stat_reg)
                         | {abort_sleep, done_s.valid};
         if (wr_fire && w_lane_reg && aw_idx_reg == 10'(`ADCRS_IDX_IRQ_MASK)) begin
            irq_mask_reg <= wbyte[1:0];
         end
         irq_o <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   // AXI4-Lite write side: address and data latched in either order
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         aw_hold_reg     <= 1'b0;
         w_hold_reg      <= 1'b0;
         aw_idx_reg      <= 10'h000;
         w_data_reg      <= 32'h0000_0000;
         w_lane_reg      <= 1'b0;
         s_axi_awready_o <= 1'b0;
         s_axi_wready_o  <= 1'b0;
         s_axi_bvalid_o  <= 1'b0;
         s_axi_bresp_o   <= 2'b00;
      end else begin
         s_axi_awready_o <= !aw_hold_reg && !s_axi_awready_o && s_axi_awvalid_i;
         s_axi_wready_o  <= !w_hold_reg && !s_axi_wready_o && s_axi_wvalid_i;
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_hold_reg <= 1'b1;
            aw_idx_reg  <= s_axi_awaddr_i[11:2];
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_hold_reg <= 1'b1;
            w_data_reg <= s_axi_wdata_i;
            w_lane_reg <= s_axi_wstrb_i[0];
         end
         if (wr_fire) begin
            aw_hold_reg    <= 1'b0;
            w_hold_reg     <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= 2'b00;
         end else if (s_axi_bvalid_o && s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
         end
      end
   end

   // AXI4-Lite read side; unmapped words read zero with OKAY
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o  <= 1'b0;
         s_axi_rdata_o   <= 32'h0000_0000;
         s_axi_rresp_o   <= 2'b00;
      end else begin
         s_axi_arready_o <= !s_axi_arready_o && !s_axi_rvalid_o && s_axi_arvalid_i;
         if (rd_fire) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rresp_o  <= 2'b00;
            if (rd_idx == 10'(`ADCRS_IDX_FLAGS)) begin
               s_axi_rdata_o <= {24'h000000, flags_reg};
            end else if (rd_idx == 10'(`ADCRS_IDX_ENABLES)) begin
               s_axi_rdata_o <= {24'h000000, enables_reg};
            end else if (rd_idx == 10'(`ADCRS_IDX_CONTROL)) begin
               s_axi_rdata_o <= {24'h000000, control_reg};   // on stays set
            end else if (rd_idx == 10'(`ADCRS_IDX_CONFIG)) begin
               s_axi_rdata_o <= {24'h000000, config_reg};
            end else if (rd_idx == 10'(`ADCRS_IDX_RES_LOW)) begin
               s_axi_rdata_o <= {24'h000000, res_low_reg};
            end else if (rd_idx == 10'(`ADCRS_IDX_RES_HIGH)) begin
               s_axi_rdata_o <= {24'h000000, res_high_reg};
            end else if (rd_idx == 10'(`ADCRS_IDX_SYSCTL)) begin
               s_axi_rdata_o <= {24'h000000, 1'b0, state_reg, 2'b00, powered_reg, por_n_i};
            end else if (rd_idx == 10'(`ADCRS_IDX_IRQ_STAT)) begin
               s_axi_rdata_o <= {30'h00000000, irq_stat_reg};
            end else if (rd_idx == 10'(`ADCRS_IDX_IRQ_MASK)) begin
               s_axi_rdata_o <= {30'h00000000, irq_mask_reg};
            end else begin
               s_axi_rdata_o <= 32'h0000_0000;
            end
         end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
         end
      end
   end

   done_clears_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      done_s.valid |=> !control_reg[`ADCRS_BIT_START] && flags_reg[`ADCRS_BIT_IRQ_FLAG])
      else $error("completion did not clear start and set flag");
   result_place_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      done_s.valid |=> {res_high_reg, res_low_reg} ==
         place_result($past(config_reg[`ADCRS_BIT_FORMAT]), $past(sample_i)))
      else $error("result misplaced");
   rc_delay_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      state_reg == adcrs_pkg::ADCRS_IDLE && start_bit && powered_reg && conv_on
      && clk_sel == adcrs_pkg::ADCRS_CLK_RC && !sleep_rise
      |=> state_reg == adcrs_pkg::ADCRS_DELAY)
      else $error("RC start not delayed");
   sleep_abort_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      abort_sleep && conv_on |=> state_reg == adcrs_pkg::ADCRS_IDLE && !powered_reg
      && control_reg[`ADCRS_BIT_ON] ##1 !analog_power_o)
      else $error("sleep abort wrong");
   quiet_off_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      done_sleep_quiet |=> !powered_reg && control_reg[`ADCRS_BIT_ON] && !wake_o)
      else $error("quiet completion did not power down");
   wake_pulse_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      done_s.valid && sleep_i && enables_reg[`ADCRS_BIT_IRQ_FLAG] |=> wake_o)
      else $error("no wake on completion");
   abort_wait_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      state_reg == adcrs_pkg::ADCRS_CONV && sw_start_clr && conv_on && !abort_sleep
      && !done_s.valid |=> state_reg == adcrs_pkg::ADCRS_WAIT && $stable(res_low_reg))
      else $error("abort did not wait");
   res_store_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      wr_fire && w_lane_reg && !conv_on && aw_idx_reg == 10'(`ADCRS_IDX_RES_LOW)
      |=> res_low_reg == $past(wbyte))
      else $error("result low not writable");
   irq_level_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      done_s.valid && irq_mask_reg[0] |-> ##[1:2] irq_o)
      else $error("interrupt not raised");

   conv_done_c:  cover property (@(posedge sys_clk_i) disable iff (!reset_n_i) done_s.valid);
   sleep_wake_c: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i) wake_o);
   sleep_abt_c:  cover property (@(posedge sys_clk_i) disable iff (!reset_n_i) abort_sleep);
   sw_abort_c:   cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      state_reg == adcrs_pkg::ADCRS_CONV && sw_start_clr);
endmodule : adcrs_core
`default_nettype wire

// [adcrs_core_tb.sv]
/*
 Self-checking bench of adcrs_core: register access over AXI4-Lite, conversions on
 every clock choice and format, sleep, aborts and reset.
 Assumes adcrs_regs.svh and adcrs_pkg.sv are compiled ahead of it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adcrs_regs.svh"
module adcrs_core_tb;
   localparam logic [7:0] FLG = `ADCRS_IDX_FLAGS, ENA = `ADCRS_IDX_ENABLES;
   localparam logic [7:0] CTL = `ADCRS_IDX_CONTROL, CFG = `ADCRS_IDX_CONFIG;
   localparam logic [7:0] RLO = `ADCRS_IDX_RES_LOW, RHI = `ADCRS_IDX_RES_HIGH;
   localparam logic [7:0] IST = `ADCRS_IDX_IRQ_STAT, IMK = `ADCRS_IDX_IRQ_MASK;
   logic        clk, rst_n, slp, awv, wv, bre, arv, rre;
   logic [11:0] awa, ara;
   logic [31:0] wd;
   logic [9:0]  smp;
   logic [15:0] res, prev;
   logic [7:0]  v;
   wire logic   awr, wrdy, bv, arr, rv, pwr, wake, irq, sreq;
   wire logic [1:0]  br, rr;
   wire logic [31:0] rdt;
   int          fail_count, n_checks, cyc, wakes;

   // Short counts keep the RC path fast; the 300-clock wait in the sleep checks relies on them
   adcrs_core #(.INSTR_CLKS(1), .RC_CLKS(2)) i_dut (
      .sys_clk_i(clk), .reset_n_i(rst_n), .por_n_i(1'b1), .sleep_i(slp),
      .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
      .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv),
      .s_axi_wready_o(wrdy), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
      .s_axi_bready_i(bre), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
      .s_axi_arready_o(arr), .s_axi_rdata_o(rdt), .s_axi_rresp_o(rr),
      .s_axi_rvalid_o(rv), .s_axi_rready_i(rre), .sample_i(smp),
      .sample_req_o(sreq), .analog_power_o(pwr), .wake_o(wake), .irq_o(irq));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : results

   // Wake is a one-cycle pulse, so it is counted at every edge
   always @(posedge clk) begin
      cyc++;
      if (wake === 1'b1) wakes++;
      if (cyc == 30000) begin
         fail_count++;
         results();
      end
   end

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic ad, dd;
      ad = 1'b0;
      dd = 1'b0;
      awa <= {2'b00, idx, 2'b00};
      wd <= {24'h000000, d};
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      while (!(ad && dd)) begin
         @(posedge clk);
         if (!ad && awr === 1'b1) begin
            ad = 1'b1;
            awv <= 1'b0;
         end
         if (!dd && wrdy === 1'b1) begin
            dd = 1'b1;
            wv <= 1'b0;
         end
      end
      do @(posedge clk); while (bv !== 1'b1);
      chk("bresp", 16'h0000, {14'h0000, br});
      bre <= 1'b0;
      @(posedge clk);
   endtask : wr

   // Plain read into v, used alone while polling
   task automatic rd(input logic [7:0] idx);
      ara <= {2'b00, idx, 2'b00};
      arv <= 1'b1;
      rre <= 1'b1;
      do @(posedge clk); while (arr !== 1'b1);
      arv <= 1'b0;
      do @(posedge clk); while (rv !== 1'b1);
      v = rdt[7:0];
      chk("rresp", 16'h0000, {14'h0000, rr});
      rre <= 1'b0;
      @(posedge clk);
   endtask : rd

   task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
      rd(idx);
      chk($sformatf("register %h", idx), {8'h00, exp}, {8'h00, v});
   endtask : rchk

   function automatic logic [15:0] place(input logic [9:0] c, input logic f);
      return f ? {6'h00, c} : {c, 6'h00};
   endfunction : place

   task automatic go(input logic [7:0] cfg, input logic s);
      smp <= 10'($urandom);
      wr(CFG, cfg);
      wr(CTL, 8'h01);
      wr(CTL, 8'h05);
      slp <= s;
      res = place(smp, cfg[5]);
   endtask : go

   task automatic pair(input logic [15:0] e);
      rchk(RLO, e[7:0]);
      rchk(RHI, e[15:8]);
   endtask : pair

   initial begin
      void'($urandom(32'hE567));
      {rst_n, slp, awv, wv, bre, arv, rre, awa, ara, wd, smp} = '0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rchk(FLG, 8'h02);
      rchk(ENA, 8'h00);
      rchk(CTL, 8'h00);
      rchk(CFG, 8'h00);
      rchk(8'h30, 8'h00);
      repeat (3) begin
         res = 16'($urandom);
         wr(RLO, res[7:0]);
         wr(RHI, res[15:8]);
         pair(res);
      end
      wr(IMK, 8'h01);
      rchk(IMK, 8'h01);
      for (int k = 0; k < 8; k++) begin
         go({k[1:0], k[2], 5'h00}, 1'b0);
         do rd(CTL); while (v[2] && cyc < 25000);
         chk("control", 16'h0001, {8'h00, v});
         pair(res);
         chk("irq", 16'h0001, {15'h0000, irq});
         rchk(FLG, 8'h22);
         rchk(IST, 8'h01);
         rchk(IST, 8'h00);
         wr(RLO, ~res[7:0]);
         pair(res);
         chk("irq", 16'h0000, {15'h0000, irq});
         wr(FLG, 8'h02);
      end
      for (int k = 0; k < 2; k++) begin
         wakes = 0;
         wr(ENA, k[0] ? 8'h00 : 8'h20);
         go(8'hE0, 1'b1);
         for (int i = 0; i < 300 && wakes == 0 && pwr === 1'b1; i++) @(posedge clk);
         chk("wake", 16'(k[0] ? 0 : 1), 16'(wakes));
         chk("power", 16'(k[0] ? 0 : 1), {15'h0000, pwr});
         slp <= 1'b0;
         rchk(CTL, 8'h01);
         pair(res);
         wr(FLG, 8'h02);
      end
      // Last completed result; every abort below must leave it in place
      prev = res;
      go(8'h40, 1'b0);
      repeat (20) @(posedge clk);
      chk("sample req", 16'h0001, {15'h0000, sreq});
      slp <= 1'b1;
      repeat (4) @(posedge clk);
      chk("power", 16'h0000, {15'h0000, pwr});
      chk("sample req", 16'h0000, {15'h0000, sreq});
      slp <= 1'b0;
      rchk(CTL, 8'h01);
      chk("on bit", 16'h0001, {15'h0000, v[0]});
      pair(prev);
      wr(CTL, 8'h01);
      wr(CTL, 8'h05);
      repeat (30) @(posedge clk);
      wr(CTL, 8'h01);
      repeat (500) @(posedge clk);
      rchk(FLG, 8'h02);
      pair(prev);
      go(8'h80, 1'b0);
      repeat (10) @(posedge clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      chk("power", 16'h0000, {15'h0000, pwr});
      rst_n <= 1'b1;
      @(posedge clk);
      rchk(CTL, 8'h00);
      rchk(`ADCRS_IDX_SYSCTL, 8'h01);
      pair(prev);
      results();
   end
endmodule : adcrs_core_tb
`default_nettype wire

// [adcrs_pkg.sv]
/*
 Types of the converter control block. Assumes adcrs_regs.svh alongside.
*/
`include "adcrs_regs.svh"
package adcrs_pkg;
   typedef enum logic [2:0] {
      ADCRS_IDLE  = 3'b000,
      ADCRS_DELAY = 3'b001,
      ADCRS_CONV  = 3'b010,
      ADCRS_WAIT  = 3'b011,
      ADCRS_OFF   = 3'b100
   } adcrs_state_t;

   typedef enum logic [1:0] {
      ADCRS_CLK_DIV8  = 2'b00,
      ADCRS_CLK_DIV32 = 2'b01,
      ADCRS_CLK_DIV64 = 2'b10,
      ADCRS_CLK_RC    = 2'b11
   } adcrs_clksel_t;

   typedef struct packed {
      logic       valid;
      logic [9:0] code;
   } adcrs_sample_t;
endpackage : adcrs_pkg

// [adcrs_regs.svh]
/*
 Register offsets, field positions, reset values and timing counts of the
 converter control block. Assumes inclusion by bare name from the package
 and the design file.
*/
`ifndef ADCRS_REGS_SVH
`define ADCRS_REGS_SVH

// Printed offsets are not all multiples of four: byte address = 4 * index
`define ADCRS_IDX_FLAGS      8'h10
`define ADCRS_IDX_ENABLES    8'h11
`define ADCRS_IDX_CONTROL    8'h14
`define ADCRS_IDX_CONFIG     8'h15
`define ADCRS_IDX_RES_LOW    8'h16
`define ADCRS_IDX_RES_HIGH   8'h17
`define ADCRS_IDX_SYSCTL     8'h20
`define ADCRS_IDX_IRQ_STAT   8'h21
`define ADCRS_IDX_IRQ_MASK   8'h22

`define ADCRS_RST_FLAGS      8'h02
`define ADCRS_RST_ENABLES    8'h00
`define ADCRS_RST_CONTROL    8'h00
`define ADCRS_RST_CONFIG     8'h00

// Field positions
`define ADCRS_BIT_IRQ_FLAG   5
`define ADCRS_BIT_START      2
`define ADCRS_BIT_ON         0
`define ADCRS_BIT_FORMAT     5
`define ADCRS_MASK_FLAGS     8'hEF
`define ADCRS_MASK_CONTROL   8'hF5
`define ADCRS_MASK_CONFIG    8'hEF

// Timing: conversion length and restart wait in conversion clock periods
`define ADCRS_CONV_PERIODS   12
`define ADCRS_ABORT_PERIODS  2
// Instruction cycle of the host core in system clocks (delay before RC start)
`define ADCRS_INSTR_CLKS     4
// Divisors for the oscillator-derived conversion clock
`define ADCRS_DIV_8          8
`define ADCRS_DIV_32         32
`define ADCRS_DIV_64         64
// Typical RC conversion period in ns and its count of system clocks (25 ns)
`define ADCRS_RC_PERIOD_NS   4000
`define ADCRS_CLK_PERIOD_NS  25
`define ADCRS_RC_CLKS        (`ADCRS_RC_PERIOD_NS / `ADCRS_CLK_PERIOD_NS)

`endif
